// ==== include/flash_cmd_pkg.sv ====
// constants for the data array command controller
package flash_cmd_pkg;
    // register indices on the special function port
    localparam logic [2:0] ADDR_COMMAND = 3'h0;
    localparam logic [2:0] ADDR_PAGE = 3'h1;
    localparam logic [2:0] ADDR_DATA1 = 3'h2;
    localparam logic [2:0] ADDR_DATA2 = 3'h3;
    localparam logic [2:0] ADDR_DATA3 = 3'h4;
    localparam logic [2:0] ADDR_DATA4 = 3'h5;
    localparam logic [2:0] ADDR_TIM_LOW = 3'h6;
    localparam logic [2:0] ADDR_TIM_HIGH = 3'h7;
    localparam logic [2:0] ADDR_TIM_AUX = 3'h0; // aux sits behind sel_aux
    // command codes
    localparam logic [7:0] CMD_READ = 8'h01;
    localparam logic [7:0] CMD_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_INTERNAL = 8'h03;
    localparam logic [7:0] CMD_VERIFY = 8'h04;
    localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
    // array geometry
    localparam int PAGES = 160;
    localparam logic [7:0] LAST_PAGE = 8'h9f;
    localparam logic [7:0] ERASED = 8'hff;
    // reset values
    localparam logic [7:0] TIM_LOW_RESET = 8'h53; // 1107 cycles, 100 us at 11.0592 MHz
    localparam logic [7:0] TIM_HIGH_RESET = 8'h04;
    localparam logic [7:0] TIM_AUX_RESET = 8'hc9;
    // durations in units of the timing word (100 us each)
    localparam int ERASE_TIME_MS = 20;
    localparam int PROGRAM_TIME_US = 250;
    localparam int UNIT_US = 100;
    localparam logic [7:0] ERASE_UNITS = 8'(ERASE_TIME_MS * 1000 / UNIT_US);
    localparam logic [7:0] PROGRAM_UNITS = 8'((PROGRAM_TIME_US + UNIT_US - 1) / UNIT_US);
endpackage

// ==== include/flash_sfr_if.sv ====
// register port between core and array controller
`timescale 1ns/1ps
`default_nettype none
interface flash_sfr_if;
    logic [2:0] addr;
    logic sel_aux;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic stall;
    modport device (input addr, sel_aux, wdata, wr, rd, output rdata, stall);
    modport core (output addr, sel_aux, wdata, wr, rd, input rdata, stall);
endinterface
`default_nettype wire

// ==== verilog/flash_cmd_ctrl.sv ====
// data array command controller: registers, array and timing
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    flash_sfr_if.device sfr
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_PROGRAM = 4'b0100,
        ST_ALL = 4'b1000
    } state_t;

    logic [7:0] mem [0:flash_cmd_pkg::PAGES*4-1];
    logic [7:0] command;
    logic [7:0] page;
    logic [7:0] data [0:3];
    logic [7:0] tim_low;
    logic [7:0] tim_high;
    logic [7:0] tim_aux;
    logic [7:0] rdata;
    logic [15:0] cycle_cnt;
    logic [7:0] unit_cnt;
    state_t state;

    // word index of a byte in the selected page
    function automatic logic [9:0] byte_at(input logic [7:0] pg, input logic [1:0] b);
        byte_at = {pg[7:0], b};
    endfunction

    // decode of a command write
    wire cmd_wr = sfr.wr && !sfr.sel_aux && sfr.addr == flash_cmd_pkg::ADDR_COMMAND;
    wire page_ok = page <= flash_cmd_pkg::LAST_PAGE;
    wire [9:0] base = byte_at(page, 2'h0);
    wire mismatch = page_ok && (mem[base] != data[0] || mem[base+10'h1] != data[1]
        || mem[base+10'h2] != data[2] || mem[base+10'h3] != data[3]);
    wire unit_done = cycle_cnt == 16'h0001 || cycle_cnt == 16'h0000;
    wire timer_done = unit_done && unit_cnt <= 8'h01;
    wire [15:0] tim_word = {tim_high, tim_low};

    assign sfr.stall = state != ST_IDLE;
    assign sfr.rdata = rdata;

    // register writes and command execution
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            command <= 8'h00;
            page <= 8'h00;
            data[0] <= 8'h00;
            data[1] <= 8'h00;
            data[2] <= 8'h00;
            data[3] <= 8'h00;
            tim_low <= flash_cmd_pkg::TIM_LOW_RESET;
            tim_high <= flash_cmd_pkg::TIM_HIGH_RESET;
            tim_aux <= flash_cmd_pkg::TIM_AUX_RESET;
            state <= ST_IDLE;
            cycle_cnt <= 16'h0000;
            unit_cnt <= 8'h00;
        end else if (state != ST_IDLE) begin
            if (unit_done) begin
                cycle_cnt <= tim_word;
                unit_cnt <= unit_cnt - 8'h01;
            end else begin
                cycle_cnt <= cycle_cnt - 16'h0001;
            end
            if (timer_done) begin
                state <= ST_IDLE;
            end
        end else if (sfr.wr && sfr.sel_aux) begin
            tim_aux <= sfr.wdata;
        end else if (sfr.wr) begin
            case (sfr.addr)
                flash_cmd_pkg::ADDR_COMMAND: begin
                    command <= sfr.wdata;
                    cycle_cnt <= tim_word;
                    case (sfr.wdata)
                        flash_cmd_pkg::CMD_READ: begin
                            if (page_ok) begin
                                data[0] <= mem[base];
                                data[1] <= mem[base+10'h1];
                                data[2] <= mem[base+10'h2];
                                data[3] <= mem[base+10'h3];
                            end
                        end
                        flash_cmd_pkg::CMD_VERIFY: begin
                            command <= mismatch ? 8'h01 : 8'h00;
                        end
                        flash_cmd_pkg::CMD_PROGRAM: begin
                            state <= ST_PROGRAM;
                            unit_cnt <= flash_cmd_pkg::PROGRAM_UNITS;
                        end
                        flash_cmd_pkg::CMD_ERASE_PAGE: begin
                            state <= ST_ERASE;
                            unit_cnt <= flash_cmd_pkg::ERASE_UNITS;
                        end
                        flash_cmd_pkg::CMD_ERASE_ALL: begin
                            state <= ST_ALL;
                            unit_cnt <= flash_cmd_pkg::ERASE_UNITS;
                        end
                        default: begin
                        end
                    endcase
                end
                flash_cmd_pkg::ADDR_PAGE: page <= sfr.wdata;
                flash_cmd_pkg::ADDR_DATA1: data[0] <= sfr.wdata;
                flash_cmd_pkg::ADDR_DATA2: data[1] <= sfr.wdata;
                flash_cmd_pkg::ADDR_DATA3: data[2] <= sfr.wdata;
                flash_cmd_pkg::ADDR_DATA4: data[3] <= sfr.wdata;
                flash_cmd_pkg::ADDR_TIM_LOW: tim_low <= sfr.wdata;
                flash_cmd_pkg::ADDR_TIM_HIGH: tim_high <= sfr.wdata;
                default: begin
                end
            endcase
        end
    end

    // array contents change at the end of a timed operation
    always_ff @(posedge clk_i) begin
        if (state != ST_IDLE && timer_done) begin
            case (state)
                ST_PROGRAM: begin
                    if (page_ok) begin
                        for (int i = 0; i < 4; i++) begin
                            mem[base+10'(i)] <= mem[base+10'(i)] & data[i];
                        end
                    end
                end
                ST_ERASE: begin
                    if (page_ok) begin
                        for (int i = 0; i < 4; i++) begin
                            mem[base+10'(i)] <= flash_cmd_pkg::ERASED;
                        end
                    end
                end
                ST_ALL: begin
                    for (int i = 0; i < flash_cmd_pkg::PAGES*4; i++) begin
                        mem[i] <= flash_cmd_pkg::ERASED;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata <= 8'h00;
        end else if (sfr.rd && sfr.sel_aux) begin
            rdata <= tim_aux;
        end else if (sfr.rd) begin
            case (sfr.addr)
                flash_cmd_pkg::ADDR_COMMAND: rdata <= command;
                flash_cmd_pkg::ADDR_PAGE: rdata <= page;
                flash_cmd_pkg::ADDR_DATA1: rdata <= data[0];
                flash_cmd_pkg::ADDR_DATA2: rdata <= data[1];
                flash_cmd_pkg::ADDR_DATA3: rdata <= data[2];
                flash_cmd_pkg::ADDR_DATA4: rdata <= data[3];
                flash_cmd_pkg::ADDR_TIM_LOW: rdata <= tim_low;
                flash_cmd_pkg::ADDR_TIM_HIGH: rdata <= tim_high;
                default: rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verilog/flash_core_port.sv ====
// core-side end: turns user requests into register strobes
`timescale 1ns/1ps
`default_nettype none
module flash_core_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // user request
    input wire logic req_wr_i,
    input wire logic req_rd_i,
    input wire logic [2:0] req_addr_i,
    input wire logic req_aux_i,
    input wire logic [7:0] req_wdata_i,
    output logic req_ready_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_valid_o,
    // register port
    flash_sfr_if.core sfr
);
    logic rd_pend;

    wire is_cmd = !req_aux_i && req_addr_i == flash_cmd_pkg::ADDR_COMMAND;
    wire bad_cmd = is_cmd && (req_wdata_i == flash_cmd_pkg::CMD_INTERNAL
        || req_wdata_i > flash_cmd_pkg::CMD_ERASE_ALL || req_wdata_i == 8'h00);
    assign req_ready_o = !sfr.stall;
    assign sfr.addr = req_addr_i;
    assign sfr.sel_aux = req_aux_i;
    assign sfr.wdata = req_wdata_i;
    assign sfr.wr = req_wr_i && !req_rd_i && !sfr.stall && !bad_cmd;
    assign sfr.rd = req_rd_i && !req_wr_i && !sfr.stall;

    // capture read answer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_pend <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
        end else begin
            rd_pend <= sfr.rd;
            rsp_valid_o <= rd_pend;
            if (rd_pend) begin
                rsp_data_o <= sfr.rdata;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/flash_cmd_properties.sv ====
// concurrent checks on the register port of the array controller
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [2:0] addr,
    input wire logic sel_aux,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic stall
);
    // command write accepted by the device
    wire cmd_wr = wr && !stall && !sel_aux && addr == 3'h0;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_ERASE_STALL: assert property (cmd_wr && wdata == 8'h05 |=> stall[*8])
        else $error("page erase did not hold the core");
    AST_ERASE_ALL_STALL: assert property (cmd_wr && wdata == 8'h06 |=> stall[*8])
        else $error("array erase did not hold the core");
    AST_PROG_STALL: assert property (cmd_wr && wdata == 8'h02 |=> stall[*4])
        else $error("program did not hold the core");
    AST_READ_FAST: assert property (cmd_wr && wdata inside {8'h01, 8'h04} |=> !stall)
        else $error("read or verify stalled the core");
    AST_STALL_CAUSE: assert property ($rose(stall) |-> $past(cmd_wr))
        else $error("stall rose without a command write");
    AST_STALL_BOUND: assert property ($rose(stall) |-> ##[1:1000] !stall)
        else $error("stall never released");
    AST_AUX_VALUE: assert property (rd && sel_aux |=> rdata == 8'hc9)
        else $error("aux timing register lost its default");
    AST_RDATA_HOLD: assert property (!$past(rd) |-> $stable(rdata))
        else $error("read data moved without a read");
endmodule
`default_nettype wire

// ==== sim/data_flash_command_controller_bench.sv ====
// self-checking bench: core port facing the array controller
`timescale 1ns/1ps
`default_nettype none
module data_flash_command_controller_bench;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic req_wr_i = 1'b0;
    logic req_rd_i = 1'b0;
    logic [2:0] req_addr_i = 3'h0;
    logic req_aux_i = 1'b0;
    logic [7:0] req_wdata_i = 8'h00;
    logic req_ready_o;
    logic [7:0] rsp_data_o;
    logic rsp_valid_o;
    int n_fail = 0;
    int num_checks = 0;
    flash_sfr_if sfr ();
    flash_cmd_ctrl u_flash_cmd_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr(sfr));
    flash_core_port u_flash_core_port (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .req_wr_i(req_wr_i), .req_rd_i(req_rd_i), .req_addr_i(req_addr_i),
        .req_aux_i(req_aux_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .rsp_data_o(rsp_data_o), .rsp_valid_o(rsp_valid_o), .sfr(sfr));
    flash_cmd_properties u_flash_cmd_properties (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .addr(sfr.addr), .sel_aux(sfr.sel_aux), .wdata(sfr.wdata), .wr(sfr.wr), .rd(sfr.rd),
        .rdata(sfr.rdata), .stall(sfr.stall));
    // 25 MHz clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one request held until the core port takes it, then one idle edge
    task automatic req(input logic w, input logic [2:0] a, input logic x, input logic [7:0] d);
        req_wr_i <= w;
        req_rd_i <= !w;
        req_addr_i <= a;
        req_aux_i <= x;
        req_wdata_i <= d;
        @(posedge clk_i);
        while (!req_ready_o) @(posedge clk_i);
        req_wr_i <= 1'b0;
        req_rd_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // register read compared at the response pulse
    task automatic rd(input logic [2:0] a, input logic x, input logic [7:0] exp);
        req(1'b0, a, x, 8'h00);
        for (int i = 0; i < 4 && rsp_valid_o !== 1'b1; i++) @(posedge clk_i);
        chk(rsp_data_o, exp);
    endtask
    task automatic op(input logic [7:0] p, input logic [31:0] d, input logic [7:0] c);
        req(1'b1, 3'h1, 1'b0, p);
        for (int i = 0; i < 4; i++) req(1'b1, 3'(2 + i), 1'b0, d[8*i +: 8]);
        req(1'b1, 3'h0, 1'b0, c);
    endtask
    // page read: no data loads before the command
    task automatic pget(input logic [7:0] p, input logic [31:0] exp);
        req(1'b1, 3'h1, 1'b0, p);
        req(1'b1, 3'h0, 1'b0, flash_cmd_pkg::CMD_READ);
        for (int i = 0; i < 4; i++) rd(3'(2 + i), 1'b0, exp[8*i +: 8]);
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        rd(3'h6, 1'b0, 8'h53);
        rd(3'h7, 1'b0, 8'h04);
        rd(3'h0, 1'b1, 8'hc9);
        // short timing word keeps erases brief
        req(1'b1, 3'h6, 1'b0, 8'h02);
        req(1'b1, 3'h7, 1'b0, 8'h00);
        rd(3'h6, 1'b0, 8'h02);
        rd(3'h7, 1'b0, 8'h00);
        req(1'b1, 3'h0, 1'b0, flash_cmd_pkg::CMD_ERASE_ALL);
        pget(8'h00, 32'hffffffff);
        pget(8'h9f, 32'hffffffff);
        op(8'h03, 32'h44332211, flash_cmd_pkg::CMD_PROGRAM);
        op(8'h04, 32'ha5c35a3c, flash_cmd_pkg::CMD_PROGRAM);
        pget(8'h03, 32'h44332211);
        op(8'h03, 32'h44332211, flash_cmd_pkg::CMD_VERIFY);
        rd(3'h0, 1'b0, 8'h00);
        op(8'h04, 32'h44332211, flash_cmd_pkg::CMD_VERIFY);
        rd(3'h0, 1'b0, 8'h01);
        // reserved codes never reach the command register
        req(1'b1, 3'h0, 1'b0, 8'h03);
        rd(3'h0, 1'b0, 8'h01);
        req(1'b1, 3'h0, 1'b0, 8'h07);
        rd(3'h0, 1'b0, 8'h01);
        req(1'b1, 3'h1, 1'b0, 8'h03);
        req(1'b1, 3'h0, 1'b0, flash_cmd_pkg::CMD_ERASE_PAGE);
        chk({7'h00, req_ready_o}, 8'h00);
        pget(8'h03, 32'hffffffff);
        pget(8'h04, 32'ha5c35a3c);
        summarize();
    end
    // watchdog well past the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
